/* File: rtl/sfcd_frame.sv */
// serial frame decoder with its write-data fifo
//
// Our own choices: the address map and the address-and-strobe port.

// ****************************************
// fifo with registered output stage
// ****************************************
module sfcd_fifo #(
  parameter int WIDTH = 29,
  parameter int DEPTH = 32
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset
  input wire logic ce, // clock enable
  input wire logic inValid, // push request
  input wire logic [WIDTH-1:0] inData, // push data
  output logic inReady, // room left
  output logic outValid, // head valid
  output logic [WIDTH-1:0] outData, // head data
  input wire logic outReady // consumer takes head
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wrPtr_r;
  logic [PW-1:0] rdPtr_r;
  logic [PW:0] cnt_r;
  logic [PW:0] cnt_nxt;
  logic outValid_r;
  logic [WIDTH-1:0] outData_r;
  wire push = ce && inValid && inReady;
  wire pop = ce && (cnt_r != '0) && (!outValid_r || outReady);
  assign inReady = cnt_r != (PW+1)'(DEPTH);
  assign cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
  assign outValid = outValid_r;
  assign outData = outData_r;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wrPtr_r] <= inData;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      cnt_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_r + PW'(push);
      rdPtr_r <= rdPtr_r + PW'(pop);
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      outValid_r <= 1'b0;
      outData_r <= '0;
    end else if (pop) begin
      outValid_r <= 1'b1;
      outData_r <= mem_r[rdPtr_r];
    end else if (ce && outReady) begin
      outValid_r <= 1'b0;
    end
  end
endmodule

// ****************************************
// frame decoder top
// ****************************************
module sfcd_frame_decode
  import sfcd_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset
  input wire logic ce, // clock enable
  input wire logic sclk, // serial clock pin
  input wire logic mosi, // host to device data pin
  input wire logic frameSelN, // frame select pin, active low
  output logic misoOut, // device to host data
  output logic misoOeN, // miso enable, low drives
  output logic rdReq, // pulse: read byte wanted
  output logic [ADDR_W-1:0] rdAddr, // read offset
  output logic [BSF_W-1:0] rdBlock, // read block code
  input wire logic [BYTE_W-1:0] rdData, // read byte
  input wire logic rdValid, // read byte strobe
  output logic wrValid, // write entry valid
  input wire logic wrReady, // write entry taken
  output logic [ADDR_W-1:0] wrAddr, // write offset
  output logic [BSF_W-1:0] wrBlock, // write block code
  output logic [BYTE_W-1:0] wrByte, // write byte
  output logic [KIND_W-1:0] blockKind, // decoded block kind
  output logic [SOCK_W-1:0] blockSocket, // decoded socket
  output logic reservedSel, // reserved block code seen
  output logic overflow, // write lost, fifo full
  output logic frameActive // frame in progress
);
  localparam int FW = ADDR_W + BSF_W + BYTE_W;
  sfcd_state_t state_r, state_nxt;
  logic sclkS1_r, sclkS2_r, sclkS3_r;
  logic mosiS1_r, mosiS2_r;
  logic fsS1_r, fsS2_r, fsS3_r;
  logic [CNT_W-1:0] bitCnt_r, bitCnt_nxt;
  logic [ADDR_W-1:0] rxSh_r, curAddr_r;
  logic [BSF_W-1:0] bsf_r;
  logic dirWrite_r, reservedSel_r, overflow_r, rdReq_r;
  logic [MODE_W-1:0] mode_r;
  logic [KIND_W-1:0] kind_r;
  logic [SOCK_W-1:0] socket_r;
  logic [LEN_W-1:0] byteCnt_r;
  logic [BYTE_W-1:0] txSh_r;
  logic misoOut_r, misoOeN_r, frameActive_r;
  logic fifoInReady;
  logic [FW-1:0] fifoOut;

  // ****************************************
  // pin synchronisers and edge finding
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      {sclkS1_r, sclkS2_r, sclkS3_r} <= 3'h0;
      {mosiS1_r, mosiS2_r} <= 2'h0;
      {fsS1_r, fsS2_r, fsS3_r} <= 3'h7;
    end else if (ce) begin
      {sclkS1_r, sclkS2_r, sclkS3_r} <= {sclk, sclkS1_r, sclkS2_r};
      {mosiS1_r, mosiS2_r} <= {mosi, mosiS1_r};
      {fsS1_r, fsS2_r, fsS3_r} <= {frameSelN, fsS1_r, fsS2_r};
    end
  end

  wire sclkRise = ce && sclkS2_r && !sclkS3_r;
  wire sclkFall = ce && !sclkS2_r && sclkS3_r;
  wire fsFall = ce && !fsS2_r && fsS3_r;
  wire fsRise = ce && fsS2_r && !fsS3_r;
  wire phaseEdge = sclkRise && !fsFall && !fsRise;
  // 16 address bits, 8 control bits
  wire addrDone = phaseEdge && state_r == ST_ADDR && bitCnt_r == ADDR_LAST;
  wire ctrlDone = phaseEdge && state_r == ST_CTRL && bitCnt_r == BYTE_LAST;
  wire byteDone = phaseEdge && state_r == ST_DATA && bitCnt_r == BYTE_LAST;
  wire phaseEnd = addrDone || ctrlDone || byteDone;
  // msb first: shift in at the bottom
  wire [ADDR_W-1:0] rxWord = {rxSh_r[ADDR_W-2:0], mosiS2_r};
  wire [BYTE_W-1:0] rxByte = rxWord[BYTE_W-1:0];
  wire [BSF_W-1:0] ctrlBsf = rxByte[BSF_MSB:BSF_LSB];
  wire ctrlDir = rxByte[DIR_BIT];
  wire [MODE_W-1:0] ctrlMode = rxByte[MODE_MSB:MODE_LSB];
  // fixed length from mode field only
  wire fixedEnd = byteDone && mode_r != MODE_VAR
    && (byteCnt_r + LEN_W'(1)) == fixedLen(mode_r);
  wire readDrive = state_r == ST_DATA && dirWrite_r == DIR_READ;
  wire pushEn = byteDone && dirWrite_r == DIR_WRITE;

  // ****************************************
  // frame sequencer
  // ****************************************
  always_comb begin
    state_nxt = state_r;
    if (fsRise) begin
      state_nxt = ST_IDLE;
    end else if (fsFall) begin
      state_nxt = ST_ADDR;
    end else begin
      case (state_r)
        ST_IDLE: if (ce && !fsS2_r) state_nxt = ST_ADDR;
        ST_ADDR: if (addrDone) state_nxt = ST_CTRL;
        ST_CTRL: if (ctrlDone) state_nxt = ST_DATA;
        // variable mode stays until select rises
        ST_DATA: if (fixedEnd) state_nxt = ST_ADDR;
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  assign bitCnt_nxt = (fsFall || fsRise || phaseEnd || state_r == ST_IDLE)
    ? CNT_ZERO : bitCnt_r + CNT_W'(phaseEdge);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      bitCnt_r <= CNT_ZERO;
      rxSh_r <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
      bitCnt_r <= bitCnt_nxt;
      if (phaseEdge) rxSh_r <= rxWord;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      curAddr_r <= '0;
      byteCnt_r <= '0;
    end else if (addrDone) begin
      curAddr_r <= rxWord;
    end else if (ctrlDone) begin
      byteCnt_r <= '0;
    end else if (byteDone) begin
      curAddr_r <= curAddr_r + ADDR_W'(1);
      byteCnt_r <= byteCnt_r + LEN_W'(1);
    end
  end

  // ****************************************
  // control byte decode
  // ****************************************
  // block field, kind and socket
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bsf_r <= BSF_COMMON;
      dirWrite_r <= DIR_READ;
      mode_r <= MODE_VAR;
      kind_r <= KIND_COMMON;
      socket_r <= '0;
      reservedSel_r <= 1'b0;
    end else if (ctrlDone) begin
      bsf_r <= ctrlBsf;
      dirWrite_r <= ctrlDir;
      mode_r <= ctrlMode;
      kind_r <= blockKindOf(ctrlBsf);
      socket_r <= ctrlBsf[BSF_W-1:KIND_W];
      reservedSel_r <= isReserved(ctrlBsf);
    end
  end

  // ****************************************
  // read data path
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdReq_r <= 1'b0;
      txSh_r <= '0;
      misoOut_r <= 1'b0;
      misoOeN_r <= 1'b1;
      frameActive_r <= 1'b0;
    end else if (ce) begin
      // direction bit 0 fetches a byte
      rdReq_r <= (ctrlDone && ctrlDir == DIR_READ)
        || (byteDone && dirWrite_r == DIR_READ && !fixedEnd);
      if (rdValid) begin
        txSh_r <= rdData;
      end else if (sclkFall && readDrive) begin
        txSh_r <= {txSh_r[BYTE_W-2:0], 1'b0};
      end
      if (sclkFall && readDrive) misoOut_r <= txSh_r[BYTE_W-1];
      misoOeN_r <= !readDrive;
      frameActive_r <= state_r != ST_IDLE;
    end
  end

  // ****************************************
  // write data path
  // ****************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      overflow_r <= 1'b0;
    end else if (pushEn && !fifoInReady) begin
      overflow_r <= 1'b1;
    end
  end

  sfcd_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .inValid(pushEn),
    .inData({curAddr_r, bsf_r, rxByte}),
    .inReady(fifoInReady),
    .outValid(wrValid),
    .outData(fifoOut),
    .outReady(wrReady)
  );

  assign {wrAddr, wrBlock, wrByte} = fifoOut;
  assign misoOut = misoOut_r;
  assign misoOeN = misoOeN_r;
  assign rdReq = rdReq_r;
  assign rdAddr = curAddr_r;
  assign rdBlock = bsf_r;
  assign blockKind = kind_r;
  assign blockSocket = socket_r;
  assign reservedSel = reservedSel_r;
  assign overflow = overflow_r;
  assign frameActive = frameActive_r;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  frame_start_a: assert property (fsFall |=>
    state_r == ST_ADDR && bitCnt_r == CNT_ZERO)
    else $error("select fall did not start address phase");
  frame_end_a: assert property (fsRise |=> state_r == ST_IDLE)
    else $error("select rise did not end frame");
  sock5_tx_a: assert property (ctrlDone && ctrlBsf == BSF_S5_TX |=>
    kind_r == KIND_TX && socket_r == SOCK_5)
    else $error("socket 5 tx decode wrong");
  sock6_rx_a: assert property (ctrlDone && ctrlBsf == BSF_S6_RX |=>
    kind_r == KIND_RX && socket_r == SOCK_6)
    else $error("socket 6 rx decode wrong");
  sock7_reg_a: assert property (ctrlDone && ctrlBsf == BSF_S7_REG |=>
    kind_r == KIND_SREG && socket_r == SOCK_7)
    else $error("socket 7 register decode wrong");
  read_request_a: assert property (
    ctrlDone && ctrlDir == DIR_READ |=> rdReq_r && rdAddr == $past(curAddr_r))
    else $error("read byte not requested");
  fixed_end_a: assert property (
    byteDone && mode_r == MODE_ONE |=> state_r == ST_ADDR)
    else $error("one byte frame did not return to address");
  var_hold_a: assert property (
    byteDone && mode_r == MODE_VAR |=> state_r == ST_DATA)
    else $error("variable frame left data phase early");
  addr_step_a: assert property (
    byteDone |=> curAddr_r == $past(curAddr_r) + ADDR_W'(1))
    else $error("offset did not step");
  miso_msb_a: assert property (
    sclkFall && readDrive |=> misoOut_r == $past(txSh_r[BYTE_W-1]))
    else $error("miso bit order wrong");
  write_push_a: assert property (
    pushEn && fifoInReady |=> ##[0:1] wrValid)
    else $error("write byte not delivered");

  var_write_c: cover property (byteDone && dirWrite_r && mode_r == MODE_VAR);
  fixed_four_c: cover property (fixedEnd && mode_r == MODE_FOUR);
  reserved_c: cover property (ctrlDone && isReserved(ctrlBsf));
  overflow_c: cover property (pushEn && !fifoInReady);
endmodule

/* File: rtl/sfcd_pkg.sv */
// constants, types and decode functions of the serial frame decoder
// Function
// - Block code 10110 selects socket 5 transmit buffer, 10111 its receive buffer.
// - Codes 11001, 11010, 11011 select socket 6 registers, transmit, receive.
// - Codes 11101, 11110, 11111 select socket 7 registers, transmit, receive.
// - Control bit 2 is direction: 0 means read, 1 means write.
// - Falling frame select starts the address phase in variable mode.
// - Mode 00 is variable length: one or more data bytes, no limit.
// - Rising frame select ends the data phase in variable mode.
// - Nonzero mode is fixed length; select stays low, length from mode.
// - Mode 01 gives a data phase of exactly one byte.
// - Mode 10 gives a data phase of exactly two bytes.
// - Mode 11 gives a data phase of exactly four bytes.
// - Data bytes shift most significant bit first on both lines.
// - Frame is 16-bit address, 8-bit control byte, then data phase.
// - Address increments by one after each data byte.
// - Block field is control bits 7..3; 00000 common, sockets in fours.
// - Modes 0 and 3 only: sample on rising, change on falling clock.
package sfcd_pkg;
  localparam int ADDR_W = 16;
  localparam int BYTE_W = 8;
  localparam int BSF_W = 5;
  localparam int CNT_W = 5;
  localparam int SOCK_W = 3;
  localparam int KIND_W = 2;
  localparam int MODE_W = 2;
  localparam int LEN_W = 3;
  localparam int FIFO_DEPTH = 32;
  localparam int BSF_MSB = 7;
  localparam int BSF_LSB = 3;
  localparam int DIR_BIT = 2;
  localparam int MODE_MSB = 1;
  localparam int MODE_LSB = 0;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] ADDR_LAST = 5'h0F;
  localparam logic [CNT_W-1:0] BYTE_LAST = 5'h07;
  localparam logic DIR_READ = 1'h0;
  localparam logic DIR_WRITE = 1'h1;
  localparam logic [MODE_W-1:0] MODE_VAR = 2'h0;
  localparam logic [MODE_W-1:0] MODE_ONE = 2'h1;
  localparam logic [MODE_W-1:0] MODE_TWO = 2'h2;
  localparam logic [MODE_W-1:0] MODE_FOUR = 2'h3;
  localparam logic [LEN_W-1:0] LEN_ONE = 3'h1;
  localparam logic [LEN_W-1:0] LEN_TWO = 3'h2;
  localparam logic [LEN_W-1:0] LEN_FOUR = 3'h4;
  localparam logic [BSF_W-1:0] BSF_COMMON = 5'h00;
  localparam logic [BSF_W-1:0] BSF_S5_TX = 5'h16;
  localparam logic [BSF_W-1:0] BSF_S5_RX = 5'h17;
  localparam logic [BSF_W-1:0] BSF_S6_REG = 5'h19;
  localparam logic [BSF_W-1:0] BSF_S6_TX = 5'h1A;
  localparam logic [BSF_W-1:0] BSF_S6_RX = 5'h1B;
  localparam logic [BSF_W-1:0] BSF_S7_REG = 5'h1D;
  localparam logic [BSF_W-1:0] BSF_S7_TX = 5'h1E;
  localparam logic [BSF_W-1:0] BSF_S7_RX = 5'h1F;
  localparam logic [SOCK_W-1:0] SOCK_5 = 3'h5;
  localparam logic [SOCK_W-1:0] SOCK_6 = 3'h6;
  localparam logic [SOCK_W-1:0] SOCK_7 = 3'h7;
  localparam logic [KIND_W-1:0] KIND_COMMON = 2'h0;
  localparam logic [KIND_W-1:0] KIND_SREG = 2'h1;
  localparam logic [KIND_W-1:0] KIND_TX = 2'h2;
  localparam logic [KIND_W-1:0] KIND_RX = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_CTRL = 2'b10,
    ST_DATA = 2'b11
  } sfcd_state_t;

  // socket codes come in groups of four: reserved, register, tx, rx
  // socket block decode
  function automatic logic [KIND_W-1:0] blockKindOf(
      input logic [BSF_W-1:0] bsf);
    blockKindOf = (bsf == BSF_COMMON) ? KIND_COMMON : bsf[KIND_W-1:0];
  endfunction

  function automatic logic isReserved(input logic [BSF_W-1:0] bsf);
    isReserved = (bsf != BSF_COMMON) && (bsf[KIND_W-1:0] == KIND_COMMON);
  endfunction

  function automatic logic [LEN_W-1:0] fixedLen(
      input logic [MODE_W-1:0] mode);
    case (mode)
      MODE_ONE: fixedLen = LEN_ONE;
      MODE_TWO: fixedLen = LEN_TWO;
      default: fixedLen = LEN_FOUR;
    endcase
  endfunction
endpackage

/* File: tb/sfcd_host.sv */
// host-side serial master model for the frame decoder bench
module sfcd_host (
  input wire logic clk, // system clock
  input wire logic miso, // device data line
  output logic sclk, // serial clock, idle low
  output logic mosi, // host data line
  output logic frameSelN // frame select, active low
);
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    frameSelN = 1'b1;
  end

  // half a link period of 160 ns
  task automatic half();
    repeat (4) @(posedge clk);
  endtask

  task automatic start();
    frameSelN <= 1'b0;
    half();
  endtask

  task automatic stop();
    half();
    frameSelN <= 1'b1;
    mosi <= ~mosi;
    half();
    half();
  endtask

  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi <= tx[i];
      half();
      // device bit has stood since the last falling edge
      rx[i] = miso;
      sclk <= 1'b1;
      half();
      sclk <= 1'b0;
    end
  endtask
endmodule

/* File: tb/sfcd_frame_decode_tb.sv */
// self-checking bench of the serial frame decoder
module sfcd_frame_decode_tb
  import sfcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic sysRst = 1'b1;
  logic ce = 1'b1;
  logic sclk, mosi, frameSelN, misoOut, misoOeN, rdReq, wrValid;
  logic rdValid = 1'b0;
  logic wrReady = 1'b1;
  logic [ADDR_W-1:0] rdAddr, wrAddr;
  logic [BSF_W-1:0] rdBlock, wrBlock;
  logic [BYTE_W-1:0] wrByte;
  logic [BYTE_W-1:0] rdData = 8'h00;
  logic [KIND_W-1:0] blockKind;
  logic [SOCK_W-1:0] blockSocket;
  logic reservedSel, overflow, frameActive;
  logic [28:0] wq[$];
  logic [7:0] rxq[$];
  int numErrors = 0;
  int comparisons = 0;
  // released line shows the inverse of the last driven bit
  wire misoLine = misoOut ^ misoOeN;

  always #20 clk = ~clk;

  sfcd_frame_decode #(.DEPTH(FIFO_DEPTH)) sfcd_frame_decode_i (
    .clk(clk), .sys_rst(sysRst), .ce(ce), .sclk(sclk), .mosi(mosi),
    .frameSelN(frameSelN), .misoOut(misoOut), .misoOeN(misoOeN),
    .rdReq(rdReq), .rdAddr(rdAddr), .rdBlock(rdBlock), .rdData(rdData),
    .rdValid(rdValid), .wrValid(wrValid), .wrReady(wrReady),
    .wrAddr(wrAddr), .wrBlock(wrBlock), .wrByte(wrByte),
    .blockKind(blockKind), .blockSocket(blockSocket),
    .reservedSel(reservedSel), .overflow(overflow),
    .frameActive(frameActive)
  );

  sfcd_host sfcd_host_i (
    .clk(clk), .miso(misoLine), .sclk(sclk), .mosi(mosi),
    .frameSelN(frameSelN)
  );

  // read bytes follow the offset; popped writes are queued
  always @(posedge clk) begin
    rdValid <= rdReq;
    rdData <= rdAddr[7:0] ^ 8'h5A;
    if (wrValid === 1'b1 && wrReady === 1'b1)
      wq.push_back({wrAddr, wrBlock, wrByte});
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      numErrors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("errors=%0d comparisons=%0d", numErrors, comparisons);
    if (numErrors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic frame(input logic [15:0] a, input logic [7:0] ctl,
      input int n, input logic variable_length_mode);
    logic [7:0] rx;
    rxq.delete();
    if (variable_length_mode)
      sfcd_host_i.start();
    sfcd_host_i.xfer(a[15:8], rx);
    sfcd_host_i.xfer(a[7:0], rx);
    sfcd_host_i.xfer(ctl, rx);
    for (int i = 0; i < n; i++) begin
      sfcd_host_i.xfer(8'hC0 + i[7:0], rx);
      rxq.push_back(rx);
    end
    if (variable_length_mode)
      sfcd_host_i.stop();
  endtask

  task automatic checkWr(input logic [15:0] a, input logic [4:0] b,
      input int n);
    logic [15:0] ea;
    repeat (50) @(posedge clk);
    chk(32'(wq.size()), 32'(n));
    for (int i = 0; i < n; i++) begin
      ea = a + i[15:0];
      chk(32'(wq[i]), 32'({ea, b, 8'hC0 + i[7:0]}));
    end
    wq.delete();
  endtask

  task automatic checkRd(input logic [15:0] a, input int n);
    logic [7:0] e;
    chk(32'(rxq.size()), 32'(n));
    for (int i = 0; i < n; i++) begin
      e = a[7:0] + i[7:0];
      chk(32'(rxq[i]), 32'(e ^ 8'h5A));
    end
    chk(32'(wq.size()), 32'h0);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic varWrite();
    frame(16'h12FE, {BSF_S6_TX, DIR_WRITE, MODE_VAR}, 3, 1'b1);
    checkWr(16'h12FE, BSF_S6_TX, 3);
    chk(32'(blockKind), 32'(KIND_TX));
    chk(32'(blockSocket), 32'(SOCK_6));
    chk(32'(frameActive), 32'h0);
  endtask

  task automatic varRead();
    frame(16'h00FF, {BSF_S7_REG, DIR_READ, MODE_VAR}, 2, 1'b1);
    checkRd(16'h00FF, 2);
    chk(32'(blockKind), 32'(KIND_SREG));
    chk(32'(blockSocket), 32'(SOCK_7));
    chk(32'(rdBlock), 32'(BSF_S7_REG));
    chk(32'(rdAddr), 32'h0101);
    chk(32'(misoOeN), 32'h1);
  endtask

  task automatic blockCodes();
    logic [4:0] codes [9] = '{BSF_S5_TX, BSF_S5_RX, BSF_S6_REG,
        BSF_S6_RX, BSF_S7_TX, BSF_S7_RX, BSF_COMMON, 5'h15, 5'h01};
    logic [4:0] c;
    for (int i = 0; i < 9; i++) begin
      c = codes[i];
      frame(16'h0040, {c, DIR_WRITE, MODE_VAR}, 1, 1'b1);
      checkWr(16'h0040, c, 1);
      chk(32'(blockKind), 32'(c[1:0]));
      chk(32'(blockSocket), 32'(c[4:2]));
      chk(32'(reservedSel), 32'(c != 5'h00 && c[1:0] == 2'h0));
    end
  endtask

  // consumer stalls: 33 entries fit, the 34th is lost
  task automatic fifoFill();
    wrReady <= 1'b0;
    frame(16'h0200, {BSF_S5_TX, DIR_WRITE, MODE_VAR}, 33, 1'b1);
    chk(32'(overflow), 32'h0);
    chk(32'(wrValid), 32'h1);
    frame(16'h0300, {BSF_S5_TX, DIR_WRITE, MODE_VAR}, 1, 1'b1);
    chk(32'(overflow), 32'h1);
    wrReady <= 1'b1;
    checkWr(16'h0200, BSF_S5_TX, 33);
    chk(32'(wrValid), 32'h0);
  endtask

  // a second reset clears the sticky loss flag and the decode
  task automatic resetMid();
    sysRst <= 1'b1;
    repeat (2) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    chk(32'(overflow), 32'h0);
    chk(32'(misoOeN), 32'h1);
    chk(32'(blockKind), 32'(KIND_COMMON));
    chk(32'(rdAddr), 32'h0);
    chk(32'(frameActive), 32'h0);
    repeat (8) @(posedge clk);
  endtask

  // select stays low from here on
  task automatic fixedModes();
    sfcd_host_i.start();
    frame(16'h0A00, {BSF_S7_RX, DIR_WRITE, MODE_ONE}, 1, 1'b0);
    checkWr(16'h0A00, BSF_S7_RX, 1);
    frame(16'h0BFF, {BSF_S6_REG, DIR_READ, MODE_TWO}, 2, 1'b0);
    checkRd(16'h0BFF, 2);
    frame(16'h0C00, {BSF_S5_RX, DIR_WRITE, MODE_FOUR}, 4, 1'b0);
    checkWr(16'h0C00, BSF_S5_RX, 4);
    chk(32'(frameActive), 32'h1);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    sysRst <= 1'b0;
    repeat (8) @(posedge clk);
    varWrite();
    varRead();
    blockCodes();
    fifoFill();
    resetMid();
    fixedModes();
    results();
  end

  // the whole run needs about 7500 cycles
  initial begin
    repeat (30000) @(posedge clk);
    numErrors++;
    results();
  end
endmodule
